// file: ddr3_burst_host.v
`include "ddr3_burst_regs.vh"
// Functional notes
// - write begins with WRITE command giving bank, column and auto precharge choice
// - a started write burst runs all its beats unless reset is asserted during it
// - controller drives one full clock write preamble with dummy crossover
// - controller holds DQS low for half-cycle postamble after last element
// - controller places first valid DQS edge WL clocks after WRITE
// - next WRITE waits until tWR recovery has run out, so write data is not seamless
// - controller waits tWTR after write data before issuing READ
// - controller waits tWR after write data before returning to idle for the next command
// - fixed BC4 starts tWR and tWTR two cycles earlier than OTF BC4
// - nonconsecutive writes may target any bank independently
// - controller captures read data on returned DQS, not CK
module ddr3_burst_host #(
    parameter WL = 5,
    parameter RL = 5
)(
    input  wire        i_sys_clk,
    input  wire        i_rst,
    input  wire [3:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    output reg  [31:0] o_avs_readdata,
    output wire        o_avs_waitrequest,
    output reg         o_ck,
    output reg  [2:0]  o_cmd,
    output reg  [2:0]  o_bank,
    output reg  [13:0] o_addr,
    output reg  [3:0]  o_dq_out,
    output reg         o_dq_oe_n,
    input  wire [3:0]  i_dq_in,
    output reg         o_dm,
    output reg         o_dqs_out,
    output reg         o_dqs_oe_n,
    input  wire        i_dqs_in
);
    localparam ST_IDLE = 3'h0;
    localparam ST_WLAT = 3'h1;
    localparam ST_DATA = 3'h2;
    localparam ST_POST = 3'h3;
    localparam ST_REC  = 3'h4;
    localparam ST_RD   = 3'h5;

    reg  [31:0] ctrl_r;
    reg  [31:0] addr_r;
    reg  [31:0] wdata_r;
    reg  [2:0]  state_r;
    reg  [3:0]  div_r;
    reg  [5:0]  cnt_r;
    reg  [3:0]  beat_r;
    reg  [4:0]  wtr_r;
    reg  [4:0]  wr_r;
    reg  [3:0]  ccd_r;
    reg  [7:0]  rdata_r;
    reg         rvalid_r;
    reg         dqs_m_r;
    reg         dqs_s_r;
    reg         dqs_d_r;
    reg  [3:0]  dq_m_r;
    reg  [3:0]  dq_s_r;
    reg         ack_r;
    wire        busy;
    wire        ck_rise;
    wire        ck_fall;
    wire        ck_mid;
    wire        bc4;
    wire [3:0]  nbeats;
    wire [4:0]  wtr_load;
    wire [4:0]  wr_load;

    assign busy    = (state_r != ST_IDLE) || ctrl_r[`CTRL_GO_BIT];
    assign ck_rise = (div_r == `CK_HALF - 4'h1) && !o_ck;
    assign ck_fall = (div_r == `CK_HALF - 4'h1) && o_ck;
    // half way between ck edges, where write data may move
    assign ck_mid  = (div_r == (`CK_HALF >> 1) - 4'h1);
    // otf chop when a12 low, fixed chop when fixbc4 set
    assign bc4      = ctrl_r[`CTRL_FIXBC4_BIT] | ~ctrl_r[`CTRL_A12_BIT];
    assign nbeats   = bc4 ? 4'h4 : 4'h8;
    // fixed chop begins recovery two cycles sooner
    assign wtr_load = ctrl_r[`CTRL_FIXBC4_BIT] ? `T_WTR_CK - `FIXBC4_EARLY : `T_WTR_CK;
    assign wr_load  = ctrl_r[`CTRL_FIXBC4_BIT] ? `T_WR_CK - `FIXBC4_EARLY : `T_WR_CK;
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;

    // avalon slave, one wait state
    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ack_r          <= 1'b0;
            o_avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
            case (i_avs_address)
                `REG_CTRL:   o_avs_readdata <= ctrl_r;
                `REG_ADDR:   o_avs_readdata <= addr_r;
                `REG_WDATA:  o_avs_readdata <= wdata_r;
                `REG_STATUS: o_avs_readdata <= {16'h0000, rdata_r, 6'h00, rvalid_r, busy};
                default:     o_avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ck divider
    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            div_r <= 4'h0;
            o_ck  <= 1'b0;
        end
        else if (div_r == `CK_HALF - 4'h1)
        begin
            div_r <= 4'h0;
            o_ck  <= ~o_ck;
        end
        else
        begin
            div_r <= div_r + 4'h1;
        end
    end

    // dqs and dq capture synchronisers
    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            dqs_m_r <= 1'b0;
            dqs_s_r <= 1'b0;
            dqs_d_r <= 1'b0;
            dq_m_r  <= 4'h0;
            dq_s_r  <= 4'h0;
        end
        else
        begin
            dqs_m_r <= i_dqs_in;
            dqs_s_r <= dqs_m_r;
            dqs_d_r <= dqs_s_r;
            dq_m_r  <= i_dq_in;
            dq_s_r  <= dq_m_r;
        end
    end

    // burst sequencer
    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_r     <= 32'h0000_0000;
            addr_r     <= 32'h0000_0000;
            wdata_r    <= 32'h0000_0000;
            state_r    <= ST_IDLE;
            cnt_r      <= 6'h00;
            beat_r     <= 4'h0;
            wtr_r      <= 5'h00;
            wr_r       <= 5'h00;
            ccd_r      <= 4'h0;
            rdata_r    <= 8'h00;
            rvalid_r   <= 1'b0;
            o_cmd      <= `CMD_NOP;
            o_bank     <= 3'h0;
            o_addr     <= 14'h0000;
            o_dq_out   <= 4'h0;
            o_dq_oe_n  <= 1'b1;
            o_dm       <= 1'b0;
            o_dqs_out  <= 1'b0;
            o_dqs_oe_n <= 1'b1;
        end
        else
        begin
            if (i_avs_write && ack_r && state_r == ST_IDLE)
            begin
                case (i_avs_address)
                    `REG_CTRL:  ctrl_r  <= i_avs_writedata;
                    `REG_ADDR:  addr_r  <= i_avs_writedata;
                    `REG_WDATA: wdata_r <= i_avs_writedata;
                    default:    ctrl_r  <= ctrl_r;
                endcase
            end
            if (ck_rise && wtr_r != 5'h00)
                wtr_r <= wtr_r - 5'h01;
            if (ck_rise && wr_r != 5'h00)
                wr_r <= wr_r - 5'h01;
            if (ck_rise && ccd_r != 4'h0)
                ccd_r <= ccd_r - 4'h1;
            if (ck_rise)
                o_cmd <= `CMD_NOP;
            case (state_r)
                ST_IDLE:
                begin
                    if (ctrl_r[`CTRL_GO_BIT] && ck_rise && ccd_r == 4'h0)
                    begin
                        if (ctrl_r[`CTRL_WRITE_BIT])
                        begin
                            o_cmd   <= `CMD_WRITE;
                            ccd_r   <= `T_CCD;
                            state_r <= ST_WLAT;
                            cnt_r   <= 6'h00;
                        end
                        else if (wtr_r == 5'h00)
                        begin
                            o_cmd    <= `CMD_READ;
                            ccd_r    <= `T_CCD;
                            rvalid_r <= 1'b0;
                            state_r  <= ST_RD;
                            cnt_r    <= 6'h00;
                            beat_r   <= 4'h0;
                        end
                        o_bank <= addr_r[`ADDR_BANK_LSB +: 3];
                        o_addr <= {1'b0, ctrl_r[`CTRL_A12_BIT], 1'b0,
                                   ctrl_r[`CTRL_AP_BIT], addr_r[`ADDR_COL_LSB +: 10]};
                    end
                end
                ST_WLAT:
                begin
                    if (ck_rise)
                        cnt_r <= cnt_r + 6'h01;
                    // preamble: high half clock, then low half clock before first edge
                    if (ck_rise && cnt_r == WL - 2)
                    begin
                        o_dqs_oe_n <= 1'b0;
                        o_dqs_out  <= 1'b1;
                    end
                    if (ck_fall && cnt_r == WL - 1)
                    begin
                        o_dqs_out <= 1'b0;
                        o_dq_oe_n <= 1'b0;
                        o_dq_out  <= wdata_r[3:0];
                        o_dm      <= wdata_r[`WDATA_MASK_LSB];
                        beat_r    <= 4'h0;
                        state_r   <= ST_DATA;
                    end
                end
                ST_DATA:
                begin
                    // each ck edge is a dqs edge; first rise at WL
                    if (ck_rise || ck_fall)
                    begin
                        o_dqs_out <= ~o_dqs_out;
                        if (beat_r == nbeats - 4'h1)
                        begin
                            state_r <= ST_POST;
                        end
                        else
                        begin
                            beat_r <= beat_r + 4'h1;
                        end
                    end
                    // data and mask move between strobe edges, centred on them
                    if (ck_mid)
                    begin
                        o_dq_out <= wdata_r[4*beat_r +: 4];
                        o_dm     <= wdata_r[`WDATA_MASK_LSB + beat_r];
                    end
                end
                ST_POST:
                begin
                    if (ck_rise || ck_fall)
                    begin
                        o_dqs_out  <= 1'b0;
                        o_dq_oe_n  <= 1'b1;
                        o_dqs_oe_n <= 1'b1;
                        wtr_r      <= wtr_load;
                        wr_r       <= wr_load;
                        state_r    <= ST_REC;
                    end
                end
                ST_REC:
                begin
                    // return to idle is held back until tWR has run
                    if (wr_r == 5'h00)
                    begin
                        ctrl_r[`CTRL_GO_BIT] <= 1'b0;
                        state_r              <= ST_IDLE;
                    end
                end
                ST_RD:
                begin
                    if (ck_rise)
                        cnt_r <= cnt_r + 6'h01;
                    // sample dq on returned strobe edges
                    if (cnt_r >= RL && (dqs_s_r != dqs_d_r) && beat_r < 4'h2)
                    begin
                        rdata_r[4*beat_r[0] +: 4] <= dq_s_r;
                        beat_r <= beat_r + 4'h1;
                    end
                    if (cnt_r == RL + 6)
                    begin
                        rvalid_r             <= (beat_r == 4'h2);
                        ctrl_r[`CTRL_GO_BIT] <= 1'b0;
                        state_r              <= ST_IDLE;
                    end
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
endmodule

// file: ddr3_burst_host_properties.sv
module ddr3_burst_host_properties #(
    parameter WL = 5,
    parameter RL = 5
)(
    input wire        i_sys_clk,
    input wire        i_rst,
    input wire [3:0]  i_avs_address,
    input wire        i_avs_read,
    input wire        i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [31:0] o_avs_readdata,
    input wire        o_avs_waitrequest,
    input wire        o_ck,
    input wire [2:0]  o_cmd,
    input wire [2:0]  o_bank,
    input wire [13:0] o_addr,
    input wire [3:0]  o_dq_out,
    input wire        o_dq_oe_n,
    input wire [3:0]  i_dq_in,
    input wire        o_dm,
    input wire        o_dqs_out,
    input wire        o_dqs_oe_n,
    input wire        i_dqs_in
);
    reg [7:0] gap_r;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // sys cycles since the write data lines were released
    always @(posedge i_sys_clk or posedge i_rst)
        if (i_rst)
            gap_r <= 8'hFF;
        else if (!o_dq_oe_n)
            gap_r <= 8'h00;
        else if (gap_r != 8'hFF)
            gap_r <= gap_r + 8'h01;
    a_cmd_at_ck: assert property ($changed(o_cmd) |-> $rose(o_ck))
        else $error("command moved away from a ck rise");
    a_ck_period: assert property ($rose(o_ck) |-> ##4 $fell(o_ck) ##4 $rose(o_ck))
        else $error("ck period is not 8 cycles");
    a_cmd_one_ck: assert property ($rose(o_cmd != 3'h7) |-> (o_cmd != 3'h7)[*8] ##1 o_cmd == 3'h7)
        else $error("command not held for one ck");
    a_wr_pre: assert property ($fell(o_dqs_oe_n) |-> o_dqs_out ##[1:8] !o_dqs_out)
        else $error("write preamble has no crossover");
    a_wr_post: assert property (!i_rst && $rose(o_dqs_oe_n) |-> !$past(o_dqs_out) && !$past(o_dqs_out, 3))
        else $error("write postamble not low");
    a_dq_in_strobe: assert property ($fell(o_dq_oe_n) |-> !o_dqs_oe_n)
        else $error("data driven without strobe");
    a_rd_after_wr: assert property ($rose(o_cmd == 3'h5) |-> gap_r >= 8'h18)
        else $error("read too soon after write data");
    a_wait_once: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("waitrequest not one cycle");
endmodule
bind ddr3_burst_host ddr3_burst_host_properties #(.WL(WL), .RL(RL)) u_props (.*);

// file: ddr3_burst_host_tb.sv
module ddr3_burst_host_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WL = 6;
    localparam int RL = 5;
    typedef struct {logic [31:0] c, a, d; int n;} row_t;
    logic        i_sys_clk = 1'b0, i_rst = 1'b1, rd = 1'b0, wr = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wd = 32'h0000_0000, q;
    wire  [31:0] rdat;
    wire         wreq, ck, dq_oe_n, dm, dqs, dqs_oe_n, dev_dqs;
    wire  [2:0]  cmd, bank;
    wire  [13:0] addr;
    wire  [3:0]  dq, dev_dq;
    int          n_errors = 0, total_checks = 0;
    row_t        rows [3];
    ddr3_burst_host #(.WL(WL), .RL(RL)) dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_ck(ck), .o_cmd(cmd),
        .o_bank(bank), .o_addr(addr), .o_dq_out(dq), .o_dq_oe_n(dq_oe_n),
        .i_dq_in(dq_oe_n ? dev_dq : dq), .o_dm(dm), .o_dqs_out(dqs),
        .o_dqs_oe_n(dqs_oe_n), .i_dqs_in(dqs_oe_n ? dev_dqs : dqs));
    ddr3_dev_model #(.WL(WL), .RL(RL)) dev (.i_clk(i_sys_clk), .i_ck(ck), .i_cmd(cmd),
        .i_bank(bank), .i_addr(addr), .i_dq(dq), .i_dm(dm), .i_dqs(dqs),
        .i_dqs_oe_n(dqs_oe_n), .o_dq(dev_dq), .o_dqs(dev_dqs));
    initial
        forever #10 i_sys_clk = ~i_sys_clk;
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge i_sys_clk);
        {adr, wd, rd, wr} <= {a, d, !w, w};
        do
        begin
            @(posedge i_sys_clk);
            k++;
        end
        while (wreq !== 1'b0 && k < 50);
        q = rdat;
        {rd, wr} <= 2'h0;
        if (k >= 50)
            n_errors++;
    endtask
    task automatic poll;
        int k;
        k = 0;
        do
        begin
            bus(0, 4'hC, 32'h0000_0000);
            k++;
        end
        while (q[0] !== 1'b0 && k < 300);
        if (k >= 300)
            n_errors++;
    endtask
    initial
    begin
        #300_000;
        n_errors++;
        summarize();
    end
    initial
    begin
        rows[0] = '{32'h0000_000B, 32'h0003_0155, 32'h0065_4321, 8};
        rows[1] = '{32'h0000_0007, 32'h0005_02AA, 32'h0200_DCBA, 4};
        rows[2] = '{32'h0000_001B, 32'h0007_03FF, 32'h0900_4E7F, 4};
        repeat (3) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        bus(0, 4'hC, 32'h0000_0000);
        chk("status", 32'h0000_0000, q);
        bus(0, 4'h2, 32'h0000_0000);
        foreach (rows[r])
        begin
            bus(1, 4'h4, rows[r].a);
            bus(1, 4'h8, rows[r].d);
            bus(1, 4'h0, rows[r].c);
            poll();
            chk("beats", rows[r].n, dev.nb);
            chk("first edge", WL, dev.wl_seen);
            chk("bank", rows[r].a[18:16], dev.bank);
            chk("column", rows[r].a[9:0], dev.col);
            chk("a12 ap", rows[r].c[3:2], {dev.a12, dev.ap});
            for (int i = 0; i < rows[r].n; i++)
            begin
                chk("mask", rows[r].d[24 + i], dev.dm[i]);
                if (!rows[r].d[24 + i])
                    chk("data", rows[r].d[4 * i +: 4], dev.beat[i]);
            end
            $display("write test %0d done", r);
        end
        bus(1, 4'h0, 32'h0000_0001);
        poll();
        chk("read valid", 1'b1, q[1]);
        chk("read data", 8'h5A, q[15:8]);
        $display("read test done");
        bus(1, 4'h0, rows[0].c);
        repeat (60) @(posedge i_sys_clk);
        i_rst <= 1'b1;
        @(negedge i_sys_clk);
        chk("cmd", 3'h7, cmd);
        chk("strobe oe", 1'b1, dqs_oe_n);
        @(posedge i_sys_clk);
        i_rst <= 1'b0;
        bus(0, 4'hC, 32'h0000_0000);
        chk("busy", 1'b0, q[0]);
        $display("reset test done");
        summarize();
    end
endmodule

// file: ddr3_burst_regs.vh
`ifndef DDR3_BURST_REGS_VH
`define DDR3_BURST_REGS_VH
// avalon register byte offsets
`define REG_CTRL        4'h0
`define REG_ADDR        4'h4
`define REG_WDATA       4'h8
`define REG_STATUS      4'hC
// control register fields
`define CTRL_GO_BIT     0
`define CTRL_WRITE_BIT  1
`define CTRL_AP_BIT     2
`define CTRL_A12_BIT    3
`define CTRL_FIXBC4_BIT 4
`define CTRL_RDDQS_BIT  5
// address register fields
`define ADDR_COL_LSB    0
`define ADDR_BANK_LSB   16
// write data register: beat nibbles from bit 0, mask bits from bit 24
`define WDATA_MASK_LSB  24
// status fields
`define STAT_BUSY_BIT   0
`define STAT_RVALID_BIT 1
`define STAT_RDATA_LSB  8
// timing counts in ck cycles
`define T_CCD           4'h4
`define T_WR_CK         5'h0A
`define T_WTR_CK        5'h04
`define FIXBC4_EARLY    5'h02
// command encodings {ras_n, cas_n, we_n}
`define CMD_NOP         3'h7
`define CMD_WRITE       3'h4
`define CMD_READ        3'h5
// sdram clock divider: ck period = 2*CK_HALF sys clocks
`define CK_HALF         4'h4
`endif

// file: ddr3_dev_model.sv
module ddr3_dev_model #(
    parameter WL = 5,
    parameter RL = 5
)(
    input  wire        i_clk,
    input  wire        i_ck,
    input  wire [2:0]  i_cmd,
    input  wire [2:0]  i_bank,
    input  wire [13:0] i_addr,
    input  wire [3:0]  i_dq,
    input  wire        i_dm,
    input  wire        i_dqs,
    input  wire        i_dqs_oe_n,
    output logic [3:0] o_dq = 4'h0,
    output logic       o_dqs = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       ck_q = 1'b0, dqs_q = 1'b0, armed = 1'b0, ap, a12;
    logic [3:0] beat [0:7];
    logic [3:0] rdat [0:3] = '{4'hA, 4'h5, 4'hC, 4'h3};
    logic [7:0] dm;
    logic [2:0] bank;
    logic [9:0] col;
    int         nb = 0, ckn = 0, wl_seen = 0, hc = -1;
    always @(posedge i_clk)
    begin
        ck_q <= i_ck;
        dqs_q <= i_dqs;
        if (i_ck != ck_q && hc >= 0)
            hc <= (hc > 2 * RL + 5) ? -1 : hc + 1;
        if (i_ck && !ck_q)
        begin
            ckn <= ckn + 1;
            if (i_cmd == 3'h4)
            begin
                {bank, col, ap, a12} <= {i_bank, i_addr[9:0], i_addr[10], i_addr[12]};
                ckn <= 0;
                nb <= 0;
                armed <= 1'b0;
            end
            if (i_cmd == 3'h5)
                hc <= 0;
        end
        // data edges count only after the preamble fall
        if (!i_dqs_oe_n && i_dqs != dqs_q)
        begin
            if (!armed)
                armed <= !i_dqs;
            else if (nb < 8)
            begin
                beat[nb] <= i_dq;
                dm[nb] <= i_dm;
                nb <= nb + 1;
                if (nb == 0)
                    wl_seen <= ckn + (i_ck && !ck_q);
            end
        end
        if (hc >= 2 * RL - 2 && hc <= 2 * RL + 4)
        begin
            o_dqs <= hc >= 2 * RL && hc <= 2 * RL + 3 && hc % 2 == 0;
            o_dq <= rdat[(hc - 2 * RL) & 3];
        end
        else
        begin
            o_dqs <= ~o_dqs;
            o_dq <= ~o_dq;
        end
    end
endmodule
